// ===== pkg/ebsp_consts.vh
`ifndef EBSP_CONSTS_VH
`define EBSP_CONSTS_VH
// ==================================================================
// Pad widths and field positions
// ==================================================================
`define EBSP_ADDR_W 26
`define EBSP_LANES 4
`define EBSP_CS_W 6
`define EBSP_BOOT_W 4
`define EBSP_MA_W 12
`define EBSP_MA_LO_W 10
`define EBSP_MA_LO_POS 1
`define EBSP_BA_NI_W 5
`define EBSP_BA_NI_POS 16
`define EBSP_BA_I_W 4
`define EBSP_BA_I_POS 21
`define EBSP_BOOT_MSB 3
// ==================================================================
// Reset values
// ==================================================================
`define EBSP_SDCS_SEL_RST 1'b1
`define EBSP_ACK_SEL_RST 1'b0
`define EBSP_BOOT_RST 4'h0
// ==================================================================
// Pad owner codes
// ==================================================================
`define EBSP_OWN_BUS 2'h0
`define EBSP_OWN_SDRAM 2'h1
`define EBSP_OWN_CARD 2'h2
`endif

// ===== rtl/ebsp_lane_map.v
`timescale 1ns/1ps
`include "ebsp_consts.vh"
// ==================================================================
// Byte lane mapping for strobe and mask pads
// ==================================================================
// Pad k carries strobe k of the bus unit, or SDRAM mask bit 3-k. Strobe k
// and mask bit k name opposite lanes; the mask word
// is therefore lane-reversed before it reaches the pads.
module ebsp_lane_map (
   // Inputs
   input wire [3:0] lane_strobe_n_i,
   input wire [3:0] lane_mask_i,
   input wire mask_sel_i,
   // Outputs
   output wire [3:0] pad_n_o
);
   genvar g;
   generate
      for (g = 0; g < `EBSP_LANES; g = g + 1) begin : g_lane
         // Pad g: strobe g gates lane 3-g; mask 3-g qualifies the same lane 3-g.
         assign pad_n_o[g] = mask_sel_i ? lane_mask_i[g] :
                             lane_strobe_n_i[g];
      end
   endgenerate
endmodule // ebsp_lane_map

// ===== rtl/ebsp_top.v
`timescale 1ns/1ps
`include "ebsp_consts.vh"
// Function
// - Read/write line high on reads, low on writes.
// - Byte strobe 0 gates D31..24, strobe 3 gates D7..0, active low.
// - SDRAM masks share strobe pads; mask 3 is D31..24, mask 0 D7..0.
// - Chip selects 3..2 share pads with SDRAM selects; SDRAM after reset (here sdram_cs_sel_i alone decides, no reset default).
// - Second SDRAM select appears on chip select 3 pad when selected.
// - Acknowledge input shares chip select 4 pad, one function at a time.
// - Non-interleave bank address on address lines 20..16.
// - Interleave bank address on address lines 24..21.
// - Low ten row/column address bits on address lines 10..1.
// - Output enable low lets memory drive data; pad also card I/O write.
// - Strobes 2, 3 and read/write double as card select, read, write.
// - Load-burst-address low makes burst memory capture start address.
// - Burst clock runs to synchronous memories during burst accesses.
module ebsp_top (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Function mux control
   input wire sdram_cs_sel_i,
   input wire ack_sel_i,
   input wire [1:0] lane_owner_i,
   input wire interleave_i,
   // External bus unit side
   input wire [25:0] bus_addr_i,
   input wire bus_read_i,
   input wire [3:0] bus_strobe_n_i,
   input wire bus_oe_n_i,
   input wire [5:0] bus_cs_n_i,
   input wire burst_active_i,
   input wire burst_start_i,
   // SDRAM controller side
   input wire sdram_active_i,
   input wire [11:0] sdram_row_col_addr_i,
   input wire [4:0] bank_addr_noninterleave_i,
   input wire [3:0] bank_addr_interleave_i,
   input wire [3:0] sdram_mask_i,
   input wire [1:0] sdram_chip_select_n_i,
   // Card interface side
   input wire card_register_select_n_i,
   input wire card_io_read_n_i,
   input wire card_io_write_n_i,
   input wire card_write_enable_n_i,
   // Pads in
   input wire end_current_burst_in_n_i,
   input wire data_acknowledge_in_n_i,
   input wire [3:0] boot_strap_i,
   // Pads out
   output reg [25:0] addr_pad_o,
   output reg [3:0] byte_pad_n_o,
   output reg oe_pad_n_o,
   output reg rw_pad_o,
   output reg [5:0] cs_pad_n_o,
   output reg cs4_pad_oe_o,
   output reg load_burst_address_n_o,
   output reg burst_clk_o,
   // To the bus unit
   output reg burst_restart_o,
   output reg data_ack_o,
   output reg [3:0] boot_mode_o,
   output reg boot_valid_o
);
   // ===============================================================
   // Lane mapping
   // ===============================================================
   reg [3:0] sel_strobe_n;
   reg [3:0] sdram_mask_rev;
   wire [3:0] lane_pad_n;
   integer k;

   always @* begin
      sel_strobe_n = bus_strobe_n_i;
      for (k = 0; k < `EBSP_LANES; k = k + 1) begin
         sdram_mask_rev[k] = sdram_mask_i[`EBSP_LANES - 1 - k];
      end
      if (lane_owner_i == `EBSP_OWN_CARD) begin
         // Card strobes take lanes 2 and 3; lanes 0 and 1 stay idle.
         sel_strobe_n = {card_io_read_n_i, card_register_select_n_i,
                         2'h3};
      end
   end

   ebsp_lane_map u_lane_map (
      .lane_strobe_n_i(sel_strobe_n),
      .lane_mask_i(sdram_mask_rev),
      .mask_sel_i(lane_owner_i == `EBSP_OWN_SDRAM),
      .pad_n_o(lane_pad_n)
   );

   // ===============================================================
   // Address pad routing
   // ===============================================================
   reg [25:0] nxt_addr;

   always @* begin
      nxt_addr = bus_addr_i;
      if (sdram_active_i) begin
         nxt_addr = 26'h0000000;
         nxt_addr[10:1] = sdram_row_col_addr_i[9:0];
         if (interleave_i) begin
            nxt_addr[24:21] = bank_addr_interleave_i;
         end else begin
            nxt_addr[20:16] = bank_addr_noninterleave_i;
         end
      end
   end

   // ===============================================================
   // Chip select and strobe pads
   // ===============================================================
   reg [5:0] nxt_cs_n;
   reg nxt_oe_n;
   reg nxt_rw;

   always @* begin
      nxt_cs_n = bus_cs_n_i;
      if (sdram_cs_sel_i) begin
         // The bus selects 3..2 are dropped, never merged.
         nxt_cs_n[3:2] = sdram_chip_select_n_i;
      end
      if (ack_sel_i) begin
         nxt_cs_n[4] = 1'b1;
      end
      nxt_oe_n = bus_oe_n_i;
      nxt_rw = bus_read_i;
      if (lane_owner_i == `EBSP_OWN_CARD) begin
         nxt_oe_n = card_io_write_n_i;
         nxt_rw = card_write_enable_n_i;
      end
   end

   // ===============================================================
   // Pad registers
   // ===============================================================
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_pad_o <= 26'h0000000;
         byte_pad_n_o <= 4'hF;
         oe_pad_n_o <= 1'b1;
         rw_pad_o <= 1'b1;
         cs_pad_n_o <= 6'h3F;
         cs4_pad_oe_o <= 1'b1;
         load_burst_address_n_o <= 1'b1;
         burst_clk_o <= 1'b0;
         burst_restart_o <= 1'b0;
         data_ack_o <= 1'b0;
      end else begin
         addr_pad_o <= nxt_addr;
         byte_pad_n_o <= lane_pad_n;
         oe_pad_n_o <= nxt_oe_n;
         rw_pad_o <= nxt_rw;
         cs_pad_n_o <= nxt_cs_n;
         cs4_pad_oe_o <= ~ack_sel_i;
         load_burst_address_n_o <= ~burst_start_i;
         // Half-rate burst clock, parked low outside bursts.
         burst_clk_o <= burst_active_i ? ~burst_clk_o : 1'b0;
         burst_restart_o <= burst_active_i &
                            ~end_current_burst_in_n_i;
         data_ack_o <= ack_sel_i & ~data_acknowledge_in_n_i;
      end
   end

   // ===============================================================
   // Boot strap capture
   // ===============================================================
   reg boot_taken_ff;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_taken_ff <= 1'b0;
         boot_mode_o <= `EBSP_BOOT_RST;
         boot_valid_o <= 1'b0;
      end else if (!boot_taken_ff) begin
         // Straps are sampled once, at the first edge after release.
         boot_taken_ff <= 1'b1;
         boot_mode_o <= {1'b0, boot_strap_i[2:0]};
         boot_valid_o <= 1'b1;
      end
   end
endmodule // ebsp_top

// ===== sim/ebsp_mem_model.sv
`timescale 1ns/1ps
// ==================================================================
// External burst flash and board straps
// ==================================================================
module ebsp_mem_model (
   input wire logic ref_clk_i,
   input wire logic end_req_i,
   output logic ecb_n_o = 1'h1,
   output logic ack_n_o = 1'h1,
   output logic [3:0] strap_o
);
   // Straps are a board constant, so they hold from power-up.
   assign strap_o = 4'h5;
   // The flash ends its burst by pulling the end line low.
   always @(posedge ref_clk_i) begin
      ecb_n_o <= !end_req_i;
      ack_n_o <= !ack_n_o;
   end
endmodule // ebsp_mem_model

// ===== sim/ebsp_monitor.sv
`timescale 1ns/1ps
module ebsp_monitor (
   input wire logic ref_clk_i, rst_n_i, sdram_cs_sel_i, ack_sel_i,
   input wire logic interleave_i, bus_read_i, sdram_active_i,
   input wire logic card_register_select_n_i, card_io_read_n_i,
   input wire logic card_io_write_n_i, card_write_enable_n_i,
   input wire logic oe_pad_n_o, rw_pad_o, cs4_pad_oe_o, boot_valid_o,
   input wire logic [1:0] lane_owner_i, sdram_chip_select_n_i,
   input wire logic [3:0] bus_strobe_n_i, sdram_mask_i, byte_pad_n_o,
   input wire logic [3:0] bank_addr_interleave_i, boot_mode_o,
   input wire logic [4:0] bank_addr_noninterleave_i,
   input wire logic [5:0] bus_cs_n_i, cs_pad_n_o,
   input wire logic [11:0] sdram_row_col_addr_i,
   input wire logic [25:0] addr_pad_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   rw_dir_a: assert property ($past(rst_n_i) && $past(lane_owner_i) == 0
      |-> rw_pad_o == $past(bus_read_i)) else $error("rw pad wrong");
   strobe_lane_a: assert property ($past(rst_n_i) && $past(lane_owner_i) == 0
      |-> byte_pad_n_o == $past(bus_strobe_n_i)) else $error("strobe wrong");
   mask_lane_a: assert property ($past(rst_n_i) && $past(lane_owner_i) == 1
      |-> {byte_pad_n_o[0], byte_pad_n_o[1], byte_pad_n_o[2], byte_pad_n_o[3]}
      == $past(sdram_mask_i)) else $error("mask lanes wrong");
   card_pads_a: assert property ($past(rst_n_i) && $past(lane_owner_i) == 2
      |-> byte_pad_n_o == {$past(card_io_read_n_i),
      $past(card_register_select_n_i), 2'h3}
      && rw_pad_o == $past(card_write_enable_n_i)
      && oe_pad_n_o == $past(card_io_write_n_i)) else $error("card pads wrong");
   sd_select_a: assert property ($past(rst_n_i) |-> cs_pad_n_o[3:2] ==
      ($past(sdram_cs_sel_i) ? $past(sdram_chip_select_n_i)
      : $past(bus_cs_n_i[3:2]))) else $error("cs3..2 wrong");
   ack_pad_a: assert property ($past(rst_n_i) && $past(ack_sel_i)
      |-> !cs4_pad_oe_o && cs_pad_n_o[4]) else $error("cs4 driven");
   bank_ni_a: assert property ($past(rst_n_i) && $past(sdram_active_i)
      && !$past(interleave_i) |-> addr_pad_o[20:16] ==
      $past(bank_addr_noninterleave_i) && addr_pad_o[10:1] ==
      $past(sdram_row_col_addr_i[9:0])) else $error("bank addr wrong");
   bank_il_a: assert property ($past(rst_n_i) && $past(sdram_active_i)
      && $past(interleave_i) |-> addr_pad_o[24:21] ==
      $past(bank_addr_interleave_i)) else $error("ibank addr wrong");
   boot_hold_a: assert property ($past(rst_n_i, 2) |-> $stable(boot_mode_o)
      && boot_valid_o && !boot_mode_o[3]) else $error("boot mode moved");
endmodule // ebsp_monitor
bind ebsp_top ebsp_monitor u_mon (.*);

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic ref_clk_i = 0, rst_n_i = 0, sdram_cs_sel_i = 1, ack_sel_i = 0;
   logic interleave_i = 0, bus_read_i = 1, bus_oe_n_i = 1, end_req = 0;
   logic burst_active_i = 0, burst_start_i = 0, sdram_active_i = 0;
   logic card_register_select_n_i = 1, card_io_read_n_i = 1;
   logic card_io_write_n_i = 1, card_write_enable_n_i = 1;
   logic end_current_burst_in_n_i, data_acknowledge_in_n_i, b;
   logic [1:0] lane_owner_i = 0, sdram_chip_select_n_i = 3;
   logic [3:0] bus_strobe_n_i = 4'hF, sdram_mask_i = 0;
   logic [3:0] bank_addr_interleave_i = 0, boot_strap_i;
   logic [3:0] byte_pad_n_o, boot_mode_o;
   logic [4:0] bank_addr_noninterleave_i = 0;
   logic [5:0] bus_cs_n_i = 6'h3F, cs_pad_n_o;
   logic [11:0] sdram_row_col_addr_i = 0;
   logic [25:0] bus_addr_i = 0, addr_pad_o;
   logic oe_pad_n_o, rw_pad_o, cs4_pad_oe_o, load_burst_address_n_o;
   logic burst_clk_o, burst_restart_o, data_ack_o, boot_valid_o;
   int bad_count = 0, n_checks = 0;
   ebsp_top DUT (.*);
   ebsp_mem_model u_mem (.ref_clk_i(ref_clk_i), .end_req_i(end_req),
      .ecb_n_o(end_current_burst_in_n_i),
      .ack_n_o(data_acknowledge_in_n_i), .strap_o(boot_strap_i));
   task chk(input logic [25:0] g, e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wt;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task t_lanes;
      @(posedge ref_clk_i);
      bus_strobe_n_i <= 4'hE;
      bus_addr_i <= 26'h2AAAAAA;
      wt;
      chk(byte_pad_n_o, 4'hE);
      chk(addr_pad_o, 26'h2AAAAAA);
      chk(rw_pad_o, 1);
      @(posedge ref_clk_i);
      lane_owner_i <= 2'h1;
      sdram_mask_i <= 4'h1;
      wt;
      chk(byte_pad_n_o, 4'h8);
      @(posedge ref_clk_i);
      lane_owner_i <= 2'h2;
      card_io_read_n_i <= 0;
      card_io_write_n_i <= 0;
      wt;
      chk(byte_pad_n_o, 4'h7);
      chk(oe_pad_n_o, 0);
   endtask
   task t_cs;
      @(posedge ref_clk_i);
      lane_owner_i <= 2'h0;
      bus_read_i <= 0;
      sdram_chip_select_n_i <= 2'h1;
      bus_cs_n_i <= 6'h33;
      ack_sel_i <= 1;
      wt;
      chk(rw_pad_o, 0);
      chk(cs_pad_n_o[3:2], 2'h1);
      chk({cs4_pad_oe_o, cs_pad_n_o[4]}, 2'h1);
      chk(data_ack_o, data_acknowledge_in_n_i);
      @(posedge ref_clk_i);
      sdram_cs_sel_i <= 0;
      ack_sel_i <= 0;
      wt;
      chk(cs_pad_n_o, 6'h33);
      chk({cs4_pad_oe_o, data_ack_o}, 2'h2);
   endtask
   task t_addr;
      @(posedge ref_clk_i);
      sdram_active_i <= 1;
      sdram_row_col_addr_i <= 12'hFFF;
      bank_addr_noninterleave_i <= 5'h15;
      bank_addr_interleave_i <= 4'hA;
      wt;
      chk(addr_pad_o[20:16], 5'h15);
      chk(addr_pad_o[10:1], 10'h3FF);
      @(posedge ref_clk_i);
      interleave_i <= 1;
      wt;
      chk(addr_pad_o[24:21], 4'hA);
   endtask
   task t_burst;
      @(posedge ref_clk_i);
      burst_active_i <= 1;
      burst_start_i <= 1;
      end_req <= 1;
      wt;
      chk(load_burst_address_n_o, 0);
      @(posedge ref_clk_i);
      burst_start_i <= 0;
      wt;
      chk(load_burst_address_n_o, 1);
      wt;
      chk(burst_restart_o, 1);
      b = burst_clk_o;
      @(posedge ref_clk_i);
      #1;
      chk(burst_clk_o, !b);
   endtask
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   initial begin
      #5000;
      bad_count++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1;
      wt;
      chk({boot_valid_o, boot_mode_o}, 5'h15);
      t_lanes;
      t_cs;
      t_addr;
      t_burst;
      finish_test;
   end
endmodule // tb
